// [sls_pkg.sv]
// sleep level sequencer package: types and timing constants
package sls_pkg;

  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned NUM_LEVELS     = 4;
  localparam int unsigned LEVEL_W        = 2;
  // motion check window, microseconds (2.3 ms)
  localparam int unsigned CHECK_US       = 2300;
  localparam int unsigned CHECK_CYCLES   = (CLK_HZ / 1_000_000) * CHECK_US;
  // sleep and dwell are counted in milliseconds
  localparam int unsigned MS_CYCLES      = CLK_HZ / 1000;
  localparam int unsigned SLEEP_W        = 16;
  localparam int unsigned THRESH_W       = 8;
  localparam int unsigned DWELL_W        = 16;
  localparam logic [1:0]  LEVEL_FIRST    = 2'h0;
  localparam logic [1:0]  LEVEL_DEEPEST  = 2'h3;

  // one sleep level parameter set
  typedef struct packed {
    logic [SLEEP_W-1:0]  sleep_ms;
    logic [THRESH_W-1:0] threshold;
    logic [DWELL_W-1:0]  dwell_ms;
  } sls_level_type;

  typedef enum logic [1:0] {
    ST_TRACK    = 2'b00,
    ST_INACTIVE = 2'b01,
    ST_CHECK    = 2'b10
  } sls_state_type;

endpackage

// [sls_tick_div.sv]
// sleep level sequencer: millisecond tick divider
module sls_tick_div #(
  parameter int unsigned DIV = 40000
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // control
  input  wire logic run,
  output logic      tick
);

  logic [31:0] count;

  // restarting on run keeps the first tick a full period away
  always_ff @(posedge clk_sys) begin
    if (rst || !run) begin
      count <= 32'h0;
      tick  <= 1'b0;
    end else if (count == 32'(DIV - 1)) begin
      count <= 32'h0;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick  <= 1'b0;
    end
  end

endmodule // sls_tick_div

// [sls_sequencer.sv]
// sleep level sequencer: power mode state machine with four sleep levels
// Function
// [RULE_01] power saving enable input; off means permanent tracking, no latency
// [RULE_02] inactive state halts sensing path while a timer keeps counting
// [RULE_03] inactive timer expiry raises wake event and restarts tracking path
// [RULE_04] each sleep level stays inactive a programmed interval then checks motion
// [RULE_05] motion found during check: wake fully into active tracking
// [RULE_06] no motion during check: return to inactive at current level
// [RULE_07] four independent parameter sets, one per sleep level
// [RULE_08] level moves are autonomous, no firmware action needed
// [RULE_09] each level has sleep interval, motion threshold and dwell time
// [RULE_10] sleep interval sets inactive time before each check at that level
// [RULE_11] leave sleep only when measured motion exceeds current threshold
// [RULE_12] time in level beyond dwell without wake advances to deeper level
// [RULE_13] each motion check window lasts 2.3 ms
// [RULE_14] with power saving, laser and detector on only when needed
// [RULE_15] without sleep levels, tracking circuitry stays on always
// [RULE_16] wake into tracking restarts at shallowest level, dwell timer cleared
// [RULE_17] deepest level keeps cycling sleep and checks, never advancing
module sls_sequencer #(
  parameter int unsigned CHECK_CYC = sls_pkg::CHECK_CYCLES,
  parameter int unsigned MS_CYC    = sls_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic                              clk_sys,
  input  wire logic                              rst,
  // configuration
  input  wire logic                              power_save_en,
  input  wire sls_pkg::sls_level_type [3:0]      level_cfg,
  // tracking path
  input  wire logic                              motion_valid,
  input  wire logic [sls_pkg::THRESH_W-1:0]      motion_amount,
  input  wire logic                              idle_request,
  // power controls and status
  output logic                                   sense_on,
  output logic                                   laser_on,
  output logic                                   timer_run,
  output logic                                   wake_irq,
  output logic [1:0]                             mode,
  output logic [sls_pkg::LEVEL_W-1:0]            level
);

  sls_pkg::sls_state_type state;
  sls_pkg::sls_state_type next_state;
  logic [sls_pkg::SLEEP_W-1:0]   sleep_count;
  logic [sls_pkg::DWELL_W-1:0]   dwell_count;
  logic [31:0]                   check_count;
  logic                          ms_tick;
  logic                          motion_hit;
  logic                          sleep_done;
  logic                          check_done;
  logic                          dwell_over;
  sls_pkg::sls_level_type        cur;

  //////////////////////////////////////////////////////////////////////////////

  assign cur = level_cfg[level]; // [RULE_07] [RULE_09]

  // timer stays running in inactive and during checks for dwell accounting
  sls_tick_div #(
    .DIV (MS_CYC)
  ) u_tick (
    .clk_sys (clk_sys),
    .rst     (rst),
    .run     (state != sls_pkg::ST_TRACK),
    .tick    (ms_tick)
  );

  assign motion_hit = motion_valid && (motion_amount > cur.threshold); // [RULE_11]
  assign sleep_done = ms_tick && (sleep_count >= cur.sleep_ms); // [RULE_10]
  assign check_done = (check_count == 32'(CHECK_CYC - 1)); // [RULE_13]
  assign dwell_over = dwell_count > cur.dwell_ms; // [RULE_12]

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_state = state;
    unique case (state)
      sls_pkg::ST_TRACK: begin
        if (power_save_en && idle_request) begin
          next_state = sls_pkg::ST_INACTIVE;
        end
      end
      sls_pkg::ST_INACTIVE: begin
        if (!power_save_en) begin
          next_state = sls_pkg::ST_TRACK; // [RULE_01]
        end else if (sleep_done) begin
          next_state = sls_pkg::ST_CHECK; // [RULE_04] [RULE_03]
        end
      end
      sls_pkg::ST_CHECK: begin
        if (!power_save_en || motion_hit) begin
          next_state = sls_pkg::ST_TRACK; // [RULE_05]
        end else if (check_done) begin
          next_state = sls_pkg::ST_INACTIVE; // [RULE_06]
        end
      end
      default: next_state = sls_pkg::ST_TRACK;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= sls_pkg::ST_TRACK;
    end else begin
      state <= next_state;
    end
  end

  // sleep interval counter, milliseconds spent inactive
  always_ff @(posedge clk_sys) begin
    if (rst || state != sls_pkg::ST_INACTIVE) begin
      sleep_count <= '0;
    end else if (ms_tick && sleep_count != '1) begin
      sleep_count <= sleep_count + 1'b1; // [RULE_02]
    end
  end

  // check window counter
  always_ff @(posedge clk_sys) begin
    if (rst || state != sls_pkg::ST_CHECK) begin
      check_count <= 32'h0;
    end else if (!check_done) begin
      check_count <= check_count + 32'h1; // [RULE_13]
    end
  end

  // level and dwell: advance autonomously, restart on wake
  // cleared on the entry edge too, so level reads shallow together with mode
  always_ff @(posedge clk_sys) begin
    if (rst || state == sls_pkg::ST_TRACK || next_state == sls_pkg::ST_TRACK) begin
      level       <= sls_pkg::LEVEL_FIRST; // [RULE_16]
      dwell_count <= '0; // [RULE_16]
    end else if (state == sls_pkg::ST_CHECK && next_state == sls_pkg::ST_INACTIVE
                 && dwell_over) begin
      dwell_count <= '0;
      if (level != sls_pkg::LEVEL_DEEPEST) begin
        level <= level + 1'b1; // [RULE_08] [RULE_12]
      end // [RULE_17]
    end else if (ms_tick && dwell_count != '1) begin
      dwell_count <= dwell_count + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // outputs registered from the next state so they align with the state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sense_on  <= 1'b1;
      laser_on  <= 1'b1;
      timer_run <= 1'b0;
      wake_irq  <= 1'b0;
      mode      <= 2'h0;
    end else begin
      sense_on  <= (next_state != sls_pkg::ST_INACTIVE); // [RULE_02] [RULE_15]
      laser_on  <= (next_state != sls_pkg::ST_INACTIVE); // [RULE_14]
      timer_run <= (next_state != sls_pkg::ST_TRACK); // [RULE_02]
      wake_irq  <= (state == sls_pkg::ST_INACTIVE) && (next_state == sls_pkg::ST_CHECK); // [RULE_03]
      mode      <= next_state;
    end
  end

endmodule // sls_sequencer

// [sls_sequencer_assertions.sv]
// assertions for the sleep level sequencer ports
module sls_sequencer_assertions #(
  parameter int unsigned CHECK_CYC = 20,
  parameter int unsigned MS_CYC    = 10
) (
  // clock and reset
  input wire logic                         clk_sys,
  input wire logic                         rst,
  // inputs
  input wire logic                         power_save_en,
  input wire sls_pkg::sls_level_type [3:0] level_cfg,
  input wire logic                         motion_valid,
  input wire logic [7:0]                   motion_amount,
  input wire logic                         idle_request,
  // outputs
  input wire logic                         sense_on,
  input wire logic                         laser_on,
  input wire logic                         timer_run,
  input wire logic                         wake_irq,
  input wire logic [1:0]                   mode,
  input wire logic [1:0]                   level
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [31:0] chk_cnt;
  // cycles spent so far in the current check window
  always_ff @(posedge clk_sys) begin
    chk_cnt <= (rst || mode != 2'h2) ? 32'h0 : chk_cnt + 32'h1;
  end
  a_laser_follows_sense: assert property (sense_on == laser_on) else $error("laser mismatch");
  a_inactive_sense_off: assert property (mode == 2'h1 |-> !sense_on && timer_run) else $error("inactive power");
  a_track_sense_on: assert property (mode == 2'h0 |-> sense_on && !timer_run) else $error("track power");
  a_wake_pulse_check: assert property (wake_irq |-> mode == 2'h2 ##1 !wake_irq) else $error("wake pulse");
  a_disable_tracks: assert property (!power_save_en |=> mode == 2'h0) else $error("disable not tracking");
  a_idle_enters: assert property (mode == 2'h0 && power_save_en && idle_request |=> mode == 2'h1 && level == 2'h0) else $error("idle entry");
  a_motion_wakes: assert property (mode == 2'h2 && power_save_en && motion_valid && motion_amount > level_cfg[level].threshold |=> mode == 2'h0 && level == 2'h0) else $error("motion wake");
  a_check_bound: assert property (chk_cnt <= CHECK_CYC) else $error("check too long");
  a_level_steps: assert property (level != $past(level) |-> level == 2'h0 || level == $past(level) + 2'h1) else $error("level jump");
  a_deepest_stays: assert property (level == 2'h3 |=> level == 2'h3 || mode == 2'h0) else $error("deepest left");
endmodule // sls_sequencer_assertions
////////////////////////////////////////////////////////////////////////////////
bind sls_sequencer sls_sequencer_assertions #(.CHECK_CYC(CHECK_CYC), .MS_CYC(MS_CYC)) chk_inst (
  .clk_sys(clk_sys), .rst(rst), .power_save_en(power_save_en), .level_cfg(level_cfg),
  .motion_valid(motion_valid), .motion_amount(motion_amount), .idle_request(idle_request),
  .sense_on(sense_on), .laser_on(laser_on), .timer_run(timer_run), .wake_irq(wake_irq),
  .mode(mode), .level(level));

// [tb.sv]
// testbench for the sleep level sequencer
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0, rst = 1'b1, power_save_en = 1'b0, motion_valid = 1'b0;
  logic idle_request = 1'b0, sense_on, laser_on, timer_run, wake_irq;
  logic [7:0] motion_amount = 8'h00;
  logic [1:0] mode, level;
  sls_pkg::sls_level_type [3:0] level_cfg;
  int error_cnt = 0, compares = 0, n;
  always #12.5 clk_sys = ~clk_sys;
  sls_sequencer #(.CHECK_CYC(20), .MS_CYC(10)) sls_sequencer_inst (.clk_sys(clk_sys),
    .rst(rst), .power_save_en(power_save_en), .level_cfg(level_cfg),
    .motion_valid(motion_valid), .motion_amount(motion_amount), .idle_request(idle_request),
    .sense_on(sense_on), .laser_on(laser_on), .timer_run(timer_run), .wake_irq(wake_irq),
    .mode(mode), .level(level));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge clk_sys);
    #2;
  endtask
  // bounded wait for a mode; a hang ends the run
  task automatic wait_mode(input logic [1:0] m, input int lim);
    n = 0;
    while (mode !== m && n < lim) begin
      step(1);
      n++;
    end
    if (n >= lim) begin
      $display("[FAIL] %0t mode wait timed out", $time);
      error_cnt++;
      summarize();
    end
  endtask
  task automatic idle_pulse();
    idle_request = 1'b1;
    step(1);
    idle_request = 1'b0;
  endtask
  task automatic summarize();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_sleep();
    power_save_en = 1'b1;
    motion_valid = 1'b1;
    idle_pulse();
    chk(mode === 2'h1 && sense_on === 1'b0 && laser_on === 1'b0 && timer_run === 1'b1, "inactive");
    wait_mode(2'h2, 200);
    chk(n >= 10 && n <= 30, "sleep interval");
    chk(wake_irq === 1'b1, "wake pulse");
    motion_amount = 8'h10;
    wait_mode(2'h1, 40);
    chk(level === 2'h0, "equal motion returns to sleep");
    wait_mode(2'h2, 200);
    motion_amount = 8'h11;
    wait_mode(2'h0, 40);
    chk(level === 2'h0 && sense_on === 1'b1, "motion wakes");
    $display("t_sleep done");
  endtask
  task automatic t_deep();
    motion_amount = 8'h00;
    idle_pulse();
    n = 0;
    while (level !== 2'h3 && n < 3000) begin
      step(1);
      n++;
    end
    chk(level === 2'h3, "reached deepest");
    // above the level 0 and 1 thresholds, equal to level 2's, below the deepest one
    motion_amount = 8'h30;
    step(300);
    chk(level === 2'h3 && mode !== 2'h0, "deepest holds");
    wait_mode(2'h2, 200);
    motion_amount = 8'h41;
    wait_mode(2'h0, 40);
    chk(level === 2'h0, "restart shallow");
    $display("t_deep done");
  endtask
  task automatic t_off();
    motion_amount = 8'h00;
    idle_pulse();
    step(3);
    power_save_en = 1'b0;
    idle_request = 1'b1;
    step(1);
    chk(mode === 2'h0 && sense_on === 1'b1, "disable wakes");
    step(5);
    chk(mode === 2'h0 && laser_on === 1'b1, "idle refused");
    $display("t_off done");
  endtask
  initial begin
    for (int i = 0; i < 4; i++) begin
      level_cfg[i] = '{sleep_ms: 16'(i + 1), threshold: 8'(16 * (i + 1)), dwell_ms: 16'h0008};
    end
    step(20);
    rst = 1'b0;
    chk(mode === 2'h0 && level === 2'h0 && sense_on === 1'b1 && timer_run === 1'b0, "reset");
    t_sleep();
    t_deep();
    t_off();
    summarize();
  end
endmodule // tb
